// ===== design/mac_stats.v
// Purpose: Statistics counter bank of a 10/100 Ethernet MAC.
// Assumes: Event pulses come from transmit and receive engines on clk.
// Notes:   Read data stand one cycle after the read strobe.
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`include "mac_stats_defs.vh"
module mac_stats
(
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // Interrupt
  output wire        irq,
  // Transmit events
  input  wire        tx_done,
  input  wire        tx_underrun,
  input  wire        tx_retry_exceeded,
  input  wire [4:0]  tx_collisions,
  input  wire        tx_deferred,
  input  wire        tx_late_coll,
  input  wire        tx_carrier_err,
  input  wire        tx_heartbeat_err,
  input  wire        tx_pause_sent,
  // Receive frame status
  input  wire        rx_done,
  input  wire [10:0] rx_length,
  input  wire        rx_crc_bad,
  input  wire        rx_odd_bits,
  input  wire        rx_symbol_err,
  input  wire        rx_is_pause,
  // Control outputs
  output wire        rx_enable,
  output wire        long_frames
);

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  reg  [31:0] mac_control_register;
  reg  [31:0] mac_config_register;
  reg  [17:0] irq_mask;
  reg  [17:0] irq_status;

  assign rx_enable   = mac_control_register[`BIT_RX_ENABLE];
  assign long_frames = mac_config_register[`BIT_LONG_FRAMES];

  always @(posedge clk)
  begin
    if (rst)
    begin
      mac_control_register <= `CONTROL_RESET;
      mac_config_register  <= `CONFIG_RESET;
      irq_mask             <= `MASK_RESET;
    end
    else if (wr)
    begin
      case (addr)
        `OFS_CONTROL:  mac_control_register <= wdata;
        `OFS_CONFIG:   mac_config_register  <= wdata;
        `OFS_IRQ_MASK: irq_mask             <= wdata[17:0];
        default:       mac_control_register <= mac_control_register;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive classification
  // ----------------------------------------------------------------------
  wire good;
  wire good_pause;
  wire crc_err;
  wire align_err;
  wire oversize;
  wire jabber;
  wire runt;
  wire code_viol;

  rx_frame_check u_check
  (
    .rx_done       (rx_done),
    .rx_length     (rx_length),
    .rx_crc_bad    (rx_crc_bad),
    .rx_odd_bits   (rx_odd_bits),
    .rx_symbol_err (rx_symbol_err),
    .rx_is_pause   (rx_is_pause),
    .long_frames   (long_frames),
    .good          (good),
    .good_pause    (good_pause),
    .crc_err       (crc_err),
    .align_err     (align_err),
    .oversize      (oversize),
    .jabber        (jabber),
    .runt          (runt),
    .code_viol     (code_viol)
  );

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  wire        tx_ok;
  wire [17:0] ev;
  wire [17:0] clr;
  wire        rd_ctr;

  assign tx_ok = tx_done && !tx_underrun && !tx_retry_exceeded;

  // Receive events are gated by the receive enable bit.
  assign ev[0]  = rx_enable && good_pause;
  assign ev[1]  = tx_ok;
  assign ev[2]  = tx_ok && (tx_collisions == 5'h01);
  assign ev[3]  = tx_ok && (tx_collisions > 5'h01);
  assign ev[4]  = rx_enable && good;
  assign ev[5]  = rx_enable && crc_err;
  assign ev[6]  = rx_enable && align_err;
  assign ev[7]  = tx_ok && tx_deferred && (tx_collisions == 5'h00);
  assign ev[8]  = tx_done && tx_late_coll && !tx_underrun;
  assign ev[9]  = tx_done && tx_retry_exceeded && !tx_underrun;
  assign ev[10] = tx_done && tx_underrun;
  assign ev[11] = tx_ok && tx_carrier_err;
  assign ev[12] = rx_enable && code_viol;
  assign ev[13] = rx_enable && oversize;
  assign ev[14] = rx_enable && jabber;
  assign ev[15] = rx_enable && runt;
  assign ev[16] = tx_done && tx_heartbeat_err && !tx_underrun;
  assign ev[17] = tx_pause_sent;

  assign rd_ctr = rd;
  assign clr[0]  = rd_ctr && (addr == `OFS_PAUSE_RX);
  assign clr[1]  = rd_ctr && (addr == `OFS_SENT_OK);
  assign clr[2]  = rd_ctr && (addr == `OFS_ONE_COLL);
  assign clr[3]  = rd_ctr && (addr == `OFS_MULTI_COLL);
  assign clr[4]  = rd_ctr && (addr == `OFS_RX_OK);
  assign clr[5]  = rd_ctr && (addr == `OFS_CRC_ERR);
  assign clr[6]  = rd_ctr && (addr == `OFS_ALIGN_ERR);
  assign clr[7]  = rd_ctr && (addr == `OFS_DEFERRED);
  assign clr[8]  = rd_ctr && (addr == `OFS_LATE_COLL);
  assign clr[9]  = rd_ctr && (addr == `OFS_RETRY_EXH);
  assign clr[10] = rd_ctr && (addr == `OFS_UNDERRUN);
  assign clr[11] = rd_ctr && (addr == `OFS_CARRIER);
  assign clr[12] = rd_ctr && (addr == `OFS_CODE_VIOL);
  assign clr[13] = rd_ctr && (addr == `OFS_OVERSIZE);
  assign clr[14] = rd_ctr && (addr == `OFS_JABBER);
  assign clr[15] = rd_ctr && (addr == `OFS_RUNT);
  assign clr[16] = rd_ctr && (addr == `OFS_HEARTBEAT);
  assign clr[17] = rd_ctr && (addr == `OFS_PAUSE_TX);

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  wire [`W_PAUSE_RX-1:0]   pause_frames_received_good_count;
  wire [`W_SENT_OK-1:0]    frames_sent_good_count;
  wire [`W_ONE_COLL-1:0]   one_collision_frame_count;
  wire [`W_MULTI_COLL-1:0] several_collision_frame_count;
  wire [`W_RX_OK-1:0]      frames_received_good_count;
  wire [`W_CRC_ERR-1:0]    crc_failure_count;
  wire [`W_ALIGN_ERR-1:0]  odd_bit_length_crc_count;
  wire [`W_DEFERRED-1:0]   deferred_send_count;
  wire [`W_SMALL-1:0]      after_slot_collision_count;
  wire [`W_SMALL-1:0]      retry_exhausted_count;
  wire [`W_SMALL-1:0]      send_fifo_starved_count;
  wire [`W_SMALL-1:0]      carrier_loss_count;
  wire [`W_SMALL-1:0]      receive_code_violation_count;
  wire [`W_SMALL-1:0]      oversize_frame_count;
  wire [`W_SMALL-1:0]      oversize_bad_crc_count;
  wire [`W_SMALL-1:0]      runt_frame_count;
  wire [`W_SMALL-1:0]      heartbeat_check_failure_count;
  wire [`W_PAUSE_TX-1:0]   pause_frames_sent_count;

  sat_counter #(.WIDTH(`W_PAUSE_RX)) u_c0
    (.clk(clk), .rst(rst), .inc(ev[0]), .clr(clr[0]),
     .count(pause_frames_received_good_count));
  sat_counter #(.WIDTH(`W_SENT_OK)) u_c1
    (.clk(clk), .rst(rst), .inc(ev[1]), .clr(clr[1]),
     .count(frames_sent_good_count));
  sat_counter #(.WIDTH(`W_ONE_COLL)) u_c2
    (.clk(clk), .rst(rst), .inc(ev[2]), .clr(clr[2]),
     .count(one_collision_frame_count));
  sat_counter #(.WIDTH(`W_MULTI_COLL)) u_c3
    (.clk(clk), .rst(rst), .inc(ev[3]), .clr(clr[3]),
     .count(several_collision_frame_count));
  sat_counter #(.WIDTH(`W_RX_OK)) u_c4
    (.clk(clk), .rst(rst), .inc(ev[4]), .clr(clr[4]),
     .count(frames_received_good_count));
  sat_counter #(.WIDTH(`W_CRC_ERR)) u_c5
    (.clk(clk), .rst(rst), .inc(ev[5]), .clr(clr[5]),
     .count(crc_failure_count));
  sat_counter #(.WIDTH(`W_ALIGN_ERR)) u_c6
    (.clk(clk), .rst(rst), .inc(ev[6]), .clr(clr[6]),
     .count(odd_bit_length_crc_count));
  sat_counter #(.WIDTH(`W_DEFERRED)) u_c7
    (.clk(clk), .rst(rst), .inc(ev[7]), .clr(clr[7]),
     .count(deferred_send_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c8
    (.clk(clk), .rst(rst), .inc(ev[8]), .clr(clr[8]),
     .count(after_slot_collision_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c9
    (.clk(clk), .rst(rst), .inc(ev[9]), .clr(clr[9]),
     .count(retry_exhausted_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c10
    (.clk(clk), .rst(rst), .inc(ev[10]), .clr(clr[10]),
     .count(send_fifo_starved_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c11
    (.clk(clk), .rst(rst), .inc(ev[11]), .clr(clr[11]),
     .count(carrier_loss_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c12
    (.clk(clk), .rst(rst), .inc(ev[12]), .clr(clr[12]),
     .count(receive_code_violation_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c13
    (.clk(clk), .rst(rst), .inc(ev[13]), .clr(clr[13]),
     .count(oversize_frame_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c14
    (.clk(clk), .rst(rst), .inc(ev[14]), .clr(clr[14]),
     .count(oversize_bad_crc_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c15
    (.clk(clk), .rst(rst), .inc(ev[15]), .clr(clr[15]),
     .count(runt_frame_count));
  sat_counter #(.WIDTH(`W_SMALL)) u_c16
    (.clk(clk), .rst(rst), .inc(ev[16]), .clr(clr[16]),
     .count(heartbeat_check_failure_count));
  sat_counter #(.WIDTH(`W_PAUSE_TX)) u_c17
    (.clk(clk), .rst(rst), .inc(ev[17]), .clr(clr[17]),
     .count(pause_frames_sent_count));

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Each counter event sets its sticky bit; a read of the status clears
  // it, but an event in that same cycle keeps its bit set.
  wire status_rd;

  assign status_rd = rd && (addr == `OFS_IRQ_STATUS);

  always @(posedge clk)
  begin
    if (rst)
      irq_status <= 18'h00000;
    else if (status_rd)
      irq_status <= ev;
    else
      irq_status <= irq_status | ev;
  end

  assign irq = |(irq_status & ~irq_mask);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `OFS_CONTROL:    next_rdata = mac_control_register;
      `OFS_CONFIG:     next_rdata = mac_config_register;
      `OFS_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
      `OFS_IRQ_MASK:   next_rdata = {14'h0000, irq_mask};
      `OFS_PAUSE_RX:   next_rdata = {16'h0000,
                                     pause_frames_received_good_count};
      `OFS_SENT_OK:    next_rdata = frames_sent_good_count;
      `OFS_ONE_COLL:   next_rdata = {16'h0000, one_collision_frame_count};
      `OFS_MULTI_COLL: next_rdata = {16'h0000,
                                     several_collision_frame_count};
      `OFS_RX_OK:      next_rdata = {8'h00, frames_received_good_count};
      `OFS_CRC_ERR:    next_rdata = {24'h000000, crc_failure_count};
      `OFS_ALIGN_ERR:  next_rdata = {24'h000000, odd_bit_length_crc_count};
      `OFS_DEFERRED:   next_rdata = {16'h0000, deferred_send_count};
      `OFS_LATE_COLL:  next_rdata = {24'h000000,
                                     after_slot_collision_count};
      `OFS_RETRY_EXH:  next_rdata = {24'h000000, retry_exhausted_count};
      `OFS_UNDERRUN:   next_rdata = {24'h000000, send_fifo_starved_count};
      `OFS_CARRIER:    next_rdata = {24'h000000, carrier_loss_count};
      `OFS_CODE_VIOL:  next_rdata = {24'h000000,
                                     receive_code_violation_count};
      `OFS_OVERSIZE:   next_rdata = {24'h000000, oversize_frame_count};
      `OFS_JABBER:     next_rdata = {24'h000000, oversize_bad_crc_count};
      `OFS_RUNT:       next_rdata = {24'h000000, runt_frame_count};
      `OFS_HEARTBEAT:  next_rdata = {24'h000000,
                                     heartbeat_check_failure_count};
      `OFS_PAUSE_TX:   next_rdata = {16'h0000, pause_frames_sent_count};
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h0000_0000;
  end

endmodule

// ===== shared/mac_stats_defs.vh
// Purpose: Offsets, widths and limits of the MAC statistics counter bank.
// Assumes: Included by the design files by its bare name.
// Notes:   Byte offsets on a 32-bit register port.
`ifndef MAC_STATS_DEFS_VH
`define MAC_STATS_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL      8'h00
`define OFS_CONFIG       8'h04
`define OFS_IRQ_STATUS   8'h24
`define OFS_IRQ_MASK     8'h28
`define OFS_PAUSE_RX     8'h3c
`define OFS_SENT_OK      8'h40
`define OFS_ONE_COLL     8'h44
`define OFS_MULTI_COLL   8'h48
`define OFS_RX_OK        8'h4c
`define OFS_CRC_ERR      8'h50
`define OFS_ALIGN_ERR    8'h54
`define OFS_DEFERRED     8'h58
`define OFS_LATE_COLL    8'h5c
`define OFS_RETRY_EXH    8'h60
`define OFS_UNDERRUN     8'h64
`define OFS_CARRIER      8'h68
`define OFS_CODE_VIOL    8'h74
`define OFS_OVERSIZE     8'h78
`define OFS_JABBER       8'h7c
`define OFS_RUNT         8'h80
`define OFS_HEARTBEAT    8'h84
`define OFS_PAUSE_TX     8'h8c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BIT_RX_ENABLE    2
`define BIT_LONG_FRAMES  4
`define CONTROL_RESET    32'h0000_0000
`define CONFIG_RESET     32'h0000_0000
`define MASK_RESET       18'h3ffff

// ----------------------------------------------------------------------
// Frame length limits in bytes
// ----------------------------------------------------------------------
`define LEN_MIN          11'd64
`define LEN_MAX_NORMAL   11'd1518
`define LEN_MAX_LONG     11'd2000

// ----------------------------------------------------------------------
// Counter widths
// ----------------------------------------------------------------------
`define W_PAUSE_RX       16
`define W_SENT_OK        32
`define W_ONE_COLL       16
`define W_MULTI_COLL     16
`define W_RX_OK          24
`define W_CRC_ERR        8
`define W_ALIGN_ERR      8
`define W_DEFERRED       16
`define W_SMALL          8
`define W_PAUSE_TX       16
`define NUM_COUNTERS     18

`endif

// ===== design/sat_counter.v
// Purpose: One saturating, clear-on-read event counter.
// Assumes: inc and clr are single-cycle pulses on clk.
// Notes:   An event in the clearing cycle is kept as a count of one.
`timescale 1ns/1ns
module sat_counter
#(
  parameter WIDTH = 8
)
(
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Control
  input  wire             inc,
  input  wire             clr,
  // Count
  output reg  [WIDTH-1:0] count
);

  wire at_max;

  assign at_max = &count;

  always @(posedge clk)
  begin
    if (rst)
      count <= {WIDTH{1'b0}};
    else if (clr)
      count <= inc ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
    else if (inc && !at_max)
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
  end

endmodule

// ===== design/rx_frame_check.v
// Purpose: Classifies one received frame for the statistics counters.
// Assumes: Frame status inputs are valid in the cycle rx_done is high.
// Notes:   Outputs are combinational pulses aligned with rx_done.
`timescale 1ns/1ns
`include "mac_stats_defs.vh"
module rx_frame_check
(
  // Frame status
  input  wire        rx_done,
  input  wire [10:0] rx_length,
  input  wire        rx_crc_bad,
  input  wire        rx_odd_bits,
  input  wire        rx_symbol_err,
  input  wire        rx_is_pause,
  // Configuration
  input  wire        long_frames,
  // Classification
  output wire        good,
  output wire        good_pause,
  output wire        crc_err,
  output wire        align_err,
  output wire        oversize,
  output wire        jabber,
  output wire        runt,
  output wire        code_viol
);

  wire [10:0] len_max;
  wire        in_window;
  wire        too_long;

  assign len_max   = long_frames ? `LEN_MAX_LONG : `LEN_MAX_NORMAL;
  assign in_window = (rx_length >= `LEN_MIN) && (rx_length <= len_max);
  assign too_long  = rx_length > len_max;

  assign good       = rx_done && in_window && !rx_crc_bad
                      && !rx_symbol_err;
  assign good_pause = good && rx_is_pause;
  assign crc_err    = rx_done && in_window && !rx_odd_bits
                      && rx_crc_bad;
  assign align_err  = rx_done && in_window && rx_odd_bits
                      && rx_crc_bad;
  assign oversize   = rx_done && too_long && !rx_crc_bad;
  assign jabber     = rx_done && too_long && rx_crc_bad;
  assign runt       = rx_done && (rx_length < `LEN_MIN) && !rx_crc_bad;
  assign code_viol  = rx_done && rx_symbol_err;

endmodule

// ===== verification/mac_stats_assertions.sv
// Purpose: Port checks on the statistics counter bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to mac_stats by the bind at the foot.
`timescale 1ns/1ns
module mac_stats_checker
(
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Register port
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  // Events and outputs
  input wire        irq,
  input wire        tx_done,
  input wire        rx_done,
  input wire        tx_pause_sent,
  input wire        rx_enable,
  input wire        long_frames
);
  wire any_ev;
  assign any_ev = tx_done | rx_done | tx_pause_sent;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_rdata_idle_zero: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("rdata not zero when idle");
  a_read_clears_count: assert property (
    (rd && !any_ev && addr >= 8'h3c && addr <= 8'h8c) ##1 (rd && $stable(addr))
    |=> rdata == 32'h0) else $error("second read not zero");
  a_rx_off_no_count: assert property (
    (rd && addr == 8'h4c && !rx_enable) ##1 (rd && addr == 8'h4c && !rx_enable)
    |=> rdata == 32'h0) else $error("receive count moved while disabled");
  a_good_upper_zero: assert property (
    $past(rd) && $past(addr) == 8'h4c |-> rdata[31:24] == 8'h0)
    else $error("good frame upper bits set");
  a_pause_upper_zero: assert property (
    $past(rd) && ($past(addr) == 8'h3c || $past(addr) == 8'h44)
    |-> rdata[31:16] == 16'h0) else $error("16-bit counter upper bits set");
  a_crc_upper_zero: assert property (
    $past(rd) && ($past(addr) == 8'h50 || $past(addr) == 8'h54)
    |-> rdata[31:8] == 24'h0) else $error("8-bit counter upper bits set");
  a_rx_enable_write: assert property (
    wr && addr == 8'h00 |=> rx_enable == $past(wdata[2]))
    else $error("rx_enable does not follow write");
  a_long_write: assert property (
    wr && addr == 8'h04 |=> long_frames == $past(wdata[4]))
    else $error("long_frames does not follow write");
  a_irq_status_clear: assert property (
    rd && addr == 8'h24 && !any_ev |=> !irq)
    else $error("irq high after status read");
  a_irq_rise_cause: assert property (
    $rose(irq) |-> $past(any_ev) || $past(wr))
    else $error("irq rose without cause");
endmodule

bind mac_stats mac_stats_checker mac_stats_checker_i (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .tx_done(tx_done), .rx_done(rx_done),
  .tx_pause_sent(tx_pause_sent), .rx_enable(rx_enable),
  .long_frames(long_frames));

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the statistics counter bank.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Events are single-cycle pulses with their qualifiers.
`timescale 1ns/1ns
module testbench;
  reg         clk;
  reg         rst;
  reg  [7:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  wire [31:0] rdata;
  wire        irq;
  reg         tx_done;
  reg  [5:0]  tq;
  reg  [4:0]  tx_collisions;
  reg         tx_pause_sent;
  reg         rx_done;
  reg  [10:0] rx_length;
  reg  [3:0]  rq;
  wire        rx_enable;
  wire        long_frames;
  reg  [31:0] last;
  integer     fail_count;
  integer     n_tests;
  integer     i;

  mac_stats mac_stats_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .tx_done(tx_done), .tx_underrun(tq[0]),
    .tx_retry_exceeded(tq[1]), .tx_collisions(tx_collisions),
    .tx_deferred(tq[2]), .tx_late_coll(tq[3]), .tx_carrier_err(tq[4]),
    .tx_heartbeat_err(tq[5]), .tx_pause_sent(tx_pause_sent),
    .rx_done(rx_done), .rx_length(rx_length), .rx_crc_bad(rq[0]),
    .rx_odd_bits(rq[1]), .rx_symbol_err(rq[2]), .rx_is_pause(rq[3]),
    .rx_enable(rx_enable), .long_frames(long_frames));

  always #5 clk = ~clk;

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task chk32(input string name, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task chk1(input string name, input exp, input got);
    chk32(name, {31'h0, exp}, {31'h0, got});
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_raw(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      last = rdata;
    end
  endtask
  task rd_reg(input [7:0] a, input [31:0] e);
    begin
      rd_raw(a);
      chk32($sformatf("register %h", a), e, last);
    end
  endtask
  task rd_two(input [7:0] a, input [31:0] e1, input [31:0] e2);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      #1;
      chk32($sformatf("first read %h", a), e1, rdata);
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk32($sformatf("second read %h", a), e2, rdata);
    end
  endtask
  task rx_frame(input [10:0] len, input [3:0] f);
    begin
      @(posedge clk);
      rx_done <= 1'b1;
      rx_length <= len;
      rq <= f;
      @(posedge clk);
      rx_done <= 1'b0;
    end
  endtask
  task tx_frame(input [4:0] coll, input [5:0] f);
    begin
      @(posedge clk);
      tx_done <= 1'b1;
      tx_collisions <= coll;
      tq <= f;
      @(posedge clk);
      tx_done <= 1'b0;
    end
  endtask
  task end_sim;
    begin
      $display("Checks made %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {addr, wdata, wr, rd, tx_done, tq, tx_collisions, tx_pause_sent} = 0;
    {rx_done, rx_length, rq} = 0;
    fail_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 8'h3c; i <= 8'h8c; i = i + 4)
      rd_reg(i[7:0], 32'h0);
    chk1("irq", 1'b0, irq);
    rd_reg(8'h28, 32'h0003ffff);
    rx_frame(11'd100, 4'h0);
    rd_two(8'h4c, 32'h0, 32'h0);
    wr_reg(8'h00, 32'h4);
    #1;
    chk1("rx_enable", 1'b1, rx_enable);
    rd_reg(8'h00, 32'h4);
    rx_frame(11'd64, 4'h0);
    rx_frame(11'd1518, 4'h0);
    rx_frame(11'd63, 4'h0);
    rx_frame(11'd1519, 4'h0);
    rx_frame(11'd100, 4'h1);
    rx_frame(11'd1600, 4'h1);
    rx_frame(11'd100, 4'h3);
    rx_frame(11'd100, 4'h4);
    rx_frame(11'd100, 4'h2);
    rd_reg(8'h4c, 32'd3);
    rd_reg(8'h50, 32'd1);
    rd_reg(8'h54, 32'd1);
    rd_reg(8'h74, 32'd1);
    rd_reg(8'h78, 32'd1);
    rd_reg(8'h7c, 32'd1);
    rd_reg(8'h80, 32'd1);
    wr_reg(8'h04, 32'h10);
    #1;
    chk1("long_frames", 1'b1, long_frames);
    rx_frame(11'd2000, 4'h0);
    rx_frame(11'd2001, 4'h0);
    rd_reg(8'h4c, 32'd1);
    rx_frame(11'd100, 4'h8);
    rx_frame(11'd100, 4'hc);
    rd_reg(8'h3c, 32'd1);
    rd_reg(8'h74, 32'd1);
    repeat (300) rx_frame(11'd100, 4'h1);
    rd_two(8'h50, 32'hff, 32'h0);
    tx_frame(5'd0, 6'h00);
    tx_frame(5'd1, 6'h00);
    tx_frame(5'd2, 6'h00);
    tx_frame(5'd0, 6'h01);
    tx_frame(5'd16, 6'h02);
    tx_frame(5'd0, 6'h04);
    @(posedge clk);
    tx_pause_sent <= 1'b1;
    @(posedge clk);
    tx_pause_sent <= 1'b0;
    rd_reg(8'h40, 32'd4);
    rd_reg(8'h44, 32'd1);
    rd_reg(8'h48, 32'd1);
    rd_reg(8'h64, 32'd1);
    rd_reg(8'h60, 32'd1);
    rd_reg(8'h58, 32'd1);
    rd_reg(8'h8c, 32'd1);
    tx_frame(5'd0, 6'h08);
    tx_frame(5'd0, 6'h10);
    tx_frame(5'd0, 6'h20);
    rd_reg(8'h5c, 32'd1);
    rd_reg(8'h68, 32'd1);
    rd_reg(8'h84, 32'd1);
    wr_reg(8'h3c, 32'h0000ffff);
    rd_reg(8'h3c, 32'h0);
    rd_reg(8'h90, 32'h0);
    rx_frame(11'd100, 4'h0);
    #1;
    chk1("irq masked", 1'b0, irq);
    wr_reg(8'h28, 32'h3ffef);
    rd_raw(8'h24);
    chk1("irq cleared", 1'b0, irq);
    rx_frame(11'd100, 4'h0);
    #1;
    chk1("irq raised", 1'b1, irq);
    rd_reg(8'h24, 32'h10);
    chk1("irq after read", 1'b0, irq);
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count = fail_count + 1;
    end_sim;
  end
endmodule
